// ===== ccw_defs.svh
`ifndef CCW_DEFS_SVH
`define CCW_DEFS_SVH
`define CCW_CTRL_ADDR 8'hc0
`define CCW_CTRL_BIT_BASE 5'h18
`define CCW_CTRL_RESET 8'h10
`define CCW_BIT_UNLOCK 0
`define CCW_BIT_ENABLE 1
`define CCW_BIT_STATUS 2
`define CCW_BIT_IRQ_MODE 3
`define CCW_PRE_LSB 4
`define CCW_PRE_MAX 4'h7
`define CCW_XTAL_HZ 32768
`define CCW_BASE_TICKS 17'h00200
`define CCW_BASE_TIMEOUT_MS 15.6
`endif

// ===== ccw_pkg.sv
package ccw_pkg;
  // ************************************************************
  // state records
  // ************************************************************
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
  } ccw_sync_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [15:0] count;
    logic armed;
    logic [7:0] rdata;
    logic rst_req;
    logic irq_req;
  } ccw_state_t;
endpackage

// ===== ccw_watchdog.sv
`include "ccw_defs.svh"
module ccw_watchdog
  import ccw_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic xtal_in,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  output logic [7:0] sfr_rdata,
  output logic wdt_reset_req,
  output logic wdt_irq
);
  // ************************************************************
  // helpers
  // ************************************************************
  // prescale above 7 is clamped so the limit fits 16 bits
  function automatic logic [15:0] ccw_term(input logic [3:0] pre);
    logic [3:0] p;
    logic [16:0] lim;
    p = (pre > `CCW_PRE_MAX) ? `CCW_PRE_MAX : pre;
    lim = `CCW_BASE_TICKS << p;
    ccw_term = 16'(lim - 17'h00001);
  endfunction

  function automatic logic ccw_hit_byte(input logic [7:0] a);
    ccw_hit_byte = (a == `CCW_CTRL_ADDR);
  endfunction

  ccw_state_t s_r;
  ccw_state_t s_nxt;
  logic tick;
  logic hit_wr;
  logic hit_bit;
  logic hit_any;
  logic access;
  logic expire;
  logic apply;
  logic [7:0] newval;
  logic [15:0] term;

  // ************************************************************
  // crystal edge
  // ************************************************************
  ccw_xtal_edge u_edge (
    .core_clk(core_clk),
    .reset(reset),
    .xtal_in(xtal_in),
    .rise(tick)
  );

  // ************************************************************
  // decode
  // ************************************************************
  always_comb begin
    hit_wr = sfr_wr && ccw_hit_byte(sfr_addr);
    hit_bit = bit_wr && (bit_addr[7:3] == `CCW_CTRL_BIT_BASE);
    hit_any = hit_wr || hit_bit;
    access = sfr_wr || sfr_rd || bit_wr;
    newval = s_r.ctl;
    if (hit_wr) begin
      newval = sfr_wdata;
    end else if (hit_bit) begin
      newval[bit_addr[2:0]] = bit_val;
    end
    term = ccw_term(s_r.ctl[7:`CCW_PRE_LSB]);
    expire = s_r.ctl[`CCW_BIT_ENABLE] && tick && (s_r.count == term);
    apply = hit_any && s_r.armed;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_req = 1'b0;
    s_nxt.irq_req = 1'b0;
    s_nxt.rdata = 8'h00;
    if (sfr_rd && ccw_hit_byte(sfr_addr)) begin
      s_nxt.rdata = s_r.ctl;
    end
    if (apply) begin
      s_nxt.ctl = newval;
      s_nxt.ctl[`CCW_BIT_UNLOCK] = 1'b0;
      s_nxt.armed = 1'b0;
    end else if (hit_any && newval[`CCW_BIT_UNLOCK]) begin
      s_nxt.armed = 1'b1;
    end else if (access) begin
      s_nxt.armed = 1'b0;
    end
    // any accepted write restarts the count, so a smaller prescale
    // can never leave the count stranded above its new limit
    if (!s_nxt.ctl[`CCW_BIT_ENABLE]) begin
      s_nxt.count = 16'h0000;
    end else if (apply) begin
      s_nxt.count = 16'h0000;
    end else if (expire) begin
      s_nxt.count = 16'h0000;
    end else if (tick) begin
      s_nxt.count = s_r.count + 16'h0001;
    end
    // expiry beats a same-cycle software clear of the flag
    if (expire) begin
      s_nxt.ctl[`CCW_BIT_STATUS] = 1'b1;
      s_nxt.irq_req = s_r.ctl[`CCW_BIT_IRQ_MODE];
      s_nxt.rst_req = ~s_r.ctl[`CCW_BIT_IRQ_MODE];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctl <= `CCW_CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;
  assign wdt_reset_req = s_r.rst_req;
  assign wdt_irq = s_r.irq_req;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_unlock;
    hit_any && !s_r.armed && newval[`CCW_BIT_UNLOCK];
  endsequence

  sequence s_data_write;
    sfr_wr && ccw_hit_byte(sfr_addr) && !sfr_wdata[`CCW_BIT_UNLOCK];
  endsequence

  property p_disabled_quiet;
    !s_r.ctl[`CCW_BIT_ENABLE] |=> !wdt_reset_req && !wdt_irq;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("watchdog acted while disabled");

  property p_disabled_count;
    !s_r.ctl[`CCW_BIT_ENABLE] && !apply |=> s_r.count == 16'h0000;
  endproperty
  a_disabled_count: assert property (p_disabled_count)
    else $error("count moved while disabled");

  property p_refresh;
    apply && newval[`CCW_BIT_ENABLE] |=> s_r.count == 16'h0000;
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh did not restart count");

  property p_expire;
    expire |=> s_r.ctl[`CCW_BIT_STATUS] && (wdt_reset_req ^ wdt_irq)
      ##1 !wdt_reset_req && !wdt_irq;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry action or flag wrong");

  property p_irq_mode;
    expire && s_r.ctl[`CCW_BIT_IRQ_MODE] |=> wdt_irq && !wdt_reset_req;
  endproperty
  a_irq_mode: assert property (p_irq_mode)
    else $error("interrupt mode gave reset");

  property p_step;
    s_r.ctl[`CCW_BIT_ENABLE] && tick && !expire && !hit_any
      |=> s_r.count == $past(s_r.count) + 16'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step on crystal edge");

  property p_hold;
    !tick && !hit_any |=> s_r.count == $past(s_r.count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved without crystal edge");

  property p_bound;
    s_r.ctl[`CCW_BIT_ENABLE] |-> s_r.count <= term;
  endproperty
  a_bound: assert property (p_bound)
    else $error("count passed selected limit");

  property p_locked;
    hit_any && !s_r.armed |=> s_r.ctl[7:3] == $past(s_r.ctl[7:3])
      && s_r.ctl[`CCW_BIT_ENABLE] == $past(s_r.ctl[`CCW_BIT_ENABLE]);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked write changed control");

  property p_unlock_write;
    s_unlock ##1 s_data_write |=> s_r.ctl[7:3] == $past(sfr_wdata[7:3]);
  endproperty
  a_unlock_write: assert property (p_unlock_write)
    else $error("unlocked write not taken");

  property p_cancel;
    s_r.armed && access && !hit_any |=> !s_r.armed;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("unlock survived other access");

  property p_unmapped_read;
    sfr_rd && !ccw_hit_byte(sfr_addr) |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");
endmodule // ccw_watchdog

// ===== ccw_xtal_edge.sv
module ccw_xtal_edge
  import ccw_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic xtal_in,
  output logic rise
);
  ccw_sync_t s_r;
  ccw_sync_t s_nxt;

  // the meta stage feeds only the sync stage
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = xtal_in;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
    s_nxt.rise = s_r.sync & ~s_r.prev;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // start as if the crystal were high, so a crystal already high at
      // release is not taken as a rising edge
      s_r <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, rise: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise = s_r.rise;
endmodule // ccw_xtal_edge

// ===== crystal_clocked_watchdog_tb.sv
module crystal_clocked_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccw_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic xtal_in = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic bit_wr = 1'b0;
  logic [7:0] bit_addr = 8'h00;
  logic bit_val = 1'b0;
  logic [7:0] sfr_rdata;
  logic wdt_reset_req;
  logic wdt_irq;
  int error_cnt = 0;
  int n_tests = 0;
  int ticks = 0;
  // ****************************
  // clocks and device
  // ****************************
  always #2 core_clk = ~core_clk;
  // crystal sped up to 16 core cycles so a run stays short
  always #32 xtal_in = ~xtal_in;
  always @(posedge xtal_in) ticks++;
  ccw_watchdog u_ccw_watchdog (
    .core_clk(core_clk),
    .reset(reset),
    .xtal_in(xtal_in),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .bit_wr(bit_wr),
    .bit_addr(bit_addr),
    .bit_val(bit_val),
    .sfr_rdata(sfr_rdata),
    .wdt_reset_req(wdt_reset_req),
    .wdt_irq(wdt_irq)
  );
  // ****************************
  // tasks
  // ****************************
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      error_cnt++;
      $display("[FAIL] %0t ticks %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    bit_addr = a;
    bit_val = v;
    bit_wr = 1'b1;
    @(posedge core_clk);
    #1;
    bit_wr = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #1;
    d = sfr_rdata;
    sfr_rd = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  // unlocked write placed just after a crystal edge has settled;
  // unlock and data go back to back, strobe held high between them
  task automatic uw(input logic [7:0] d);
    int k;
    logic last;
    last = xtal_in;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      #1;
      if (xtal_in && !last) break;
      last = xtal_in;
    end
    if (k == 40) begin
      error_cnt++;
      $display("[FAIL] %0t no crystal edge", $time);
      complete_run();
    end
    repeat (5) @(posedge core_clk);
    #1;
    sfr_addr = 8'hc0;
    sfr_wdata = 8'h01;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_wdata = d;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
    ticks = 0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic quiet(input int n);
    logic [1:0] seen;
    seen = 2'b00;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      seen = seen | {wdt_irq, wdt_reset_req};
    end
    chk8({6'h00, seen}, 8'h00);
  endtask
  task automatic pulse(input logic irq, input int exp_ticks);
    int k;
    for (k = 0; k < 40000; k++) begin
      @(posedge core_clk);
      #1;
      if (wdt_irq === 1'b1 || wdt_reset_req === 1'b1) break;
    end
    if (k == 40000) begin
      error_cnt++;
      $display("[FAIL] %0t no timeout pulse", $time);
      complete_run();
    end
    chk8({6'h00, wdt_irq, wdt_reset_req}, {6'h00, irq, ~irq});
    chkn(ticks, exp_ticks);
  endtask
  // ****************************
  // sequence
  // ****************************
  initial begin
    logic [7:0] r;
    repeat (3) @(posedge core_clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    rd(8'hc0, r);
    chk8(r, 8'h10);
    wr(8'hc0, 8'h0a);
    rd(8'hc0, r);
    chk8(r, 8'h10);
    wr(8'hc0, 8'h01);
    rd(8'h80, r);
    chk8(r, 8'h00);
    wr(8'hc0, 8'h0a);
    rd(8'hc0, r);
    chk8(r, 8'h10);
    bw(8'hc0, 1'b1);
    bw(8'hc3, 1'b1);
    rd(8'hc0, r);
    chk8(r, 8'h18);
    bw(8'hc1, 1'b1);
    rd(8'hc0, r);
    chk8(r, 8'h18);
    uw(8'h0a);
    quiet(4800);
    uw(8'h0a);
    pulse(1'b1, 512);
    rd(8'hc0, r);
    chk8(r, 8'h0e);
    uw(8'h08);
    quiet(11200);
    rd(8'hc0, r);
    chk8(r, 8'h08);
    uw(8'h12);
    pulse(1'b0, 1024);
    rd(8'hc0, r);
    chk8(r, 8'h16);
    complete_run();
  end
endmodule // crystal_clocked_watchdog_tb
